// file: src/odp_pkg.sv
// package for the overload duty protection block: constants, setting codes and carriers
// assumes current figures in 0.1 A, frequency in 0.01 Hz, percentages in whole percent
package odp_pkg;

	// ******************************
	// duty codes and timing
	// ******************************
	localparam logic [1:0] ODP_DUTY_ND = 2'h1;
	localparam logic [1:0] ODP_DUTY_HD = 2'h2;
	localparam int ODP_CLK_NS = 8;
	localparam int ODP_TICK_NS = 1000000;
	localparam int ODP_TICK_CYCLES = ODP_TICK_NS / ODP_CLK_NS;
	localparam int ODP_TICK_MS = 1;
	localparam int ODP_LONG_MS = 60000;
	localparam int ODP_SHORT_MS = 2500;
	localparam int ODP_LONG_TICKS = ODP_LONG_MS / ODP_TICK_MS;
	localparam int ODP_SHORT_TICKS = ODP_SHORT_MS / ODP_TICK_MS;

	// ******************************
	// curve points in percent, low-frequency corner in 0.01 Hz
	// ******************************
	localparam logic [15:0] ODP_PCT_FULL = 16'h0064;
	localparam logic [15:0] ODP_ND_MAIN = 16'h0078;
	localparam logic [15:0] ODP_ND_STEEP_ON = 16'h007A;
	localparam logic [15:0] ODP_ND_STEEP_TRIP = 16'h008C;
	localparam logic [15:0] ODP_ND_LOWF = 16'h003C;
	localparam logic [15:0] ODP_ND_MARGIN = 16'h0014;
	localparam logic [15:0] ODP_HD_MAIN = 16'h0096;
	localparam logic [15:0] ODP_HD_STEEP_ON = 16'h009B;
	localparam logic [15:0] ODP_HD_STEEP_TRIP = 16'h00AF;
	localparam logic [15:0] ODP_HD_LOWF = 16'h004B;
	localparam logic [15:0] ODP_HD_MARGIN = 16'h0032;
	localparam logic [15:0] ODP_LOWF_HZ = 16'h0064;

	// ******************************
	// setting ranges and defaults
	// ******************************
	localparam logic [15:0] ODP_LIM_MIN = 16'h0032;
	localparam logic [15:0] ODP_LIM_MAX = 16'h012C;
	localparam logic [15:0] ODP_LIM_DEF_ND = 16'h007D;
	localparam logic [15:0] ODP_LIM_DEF_HD = 16'h009B;
	localparam logic [15:0] ODP_BRK_MIN = 16'h006E;
	localparam logic [15:0] ODP_BRK_MAX = 16'h012C;
	localparam logic [15:0] ODP_BRK_DEF_ND = 16'h0078;
	localparam logic [15:0] ODP_BRK_DEF_HD = 16'h0096;
	localparam logic [15:0] ODP_BASE_DEF = 16'h0064;
	localparam logic [15:0] ODP_BASE_MIN = 16'h0032;
	localparam logic [15:0] ODP_MRATED_MIN_NUM = 16'h0003;
	localparam logic [15:0] ODP_MRATED_MIN_DEN = 16'h000A;

	typedef enum logic [2:0] {
		ODP_SEL_DUTY = 3'h0,
		ODP_SEL_LIMIT = 3'h1,
		ODP_SEL_BRK = 3'h2,
		ODP_SEL_BASE = 3'h3,
		ODP_SEL_MRATED = 3'h4
	} odp_sel_type;

	// one setting write from the operator panel
	typedef struct packed {
		logic wr;
		odp_sel_type sel;
		logic [15:0] data;
	} odp_wr_type;

	// trip flags, all sticky until fault reset
	typedef struct packed {
		logic unit_main;
		logic unit_steep;
		logic motor;
	} odp_trip_type;

endpackage : odp_pkg

// file: src/odp_acc.sv
// inverse-time accumulator: integrates excess percent above a pickup, trips at a level
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module odp_acc (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic tick,
	input wire logic clear,
	input wire logic [15:0] pct,
	input wire logic [15:0] pickup,
	input wire logic [31:0] level,
	output logic trip
);
	import odp_pkg::*;

	logic [31:0] acc_q, acc_d;
	logic trip_q, trip_d;
	logic [32:0] sum;

	// ******************************
	// next state
	// ******************************
	// below pickup the store bleeds off so a short overload is forgotten over time
	always_comb begin
		acc_d = acc_q;
		sum = {1'b0, acc_q} + {17'h00000, pct - pickup};
		if (tick) begin
			if (pct > pickup)
				acc_d = sum[32] ? 32'hFFFFFFFF : sum[31:0];
			else if (acc_q > {16'h0000, pickup - pct})
				acc_d = acc_q - {16'h0000, pickup - pct};
			else
				acc_d = 32'h00000000;
		end
		// a trip arriving with the clear still wins
		trip_d = (trip_q && !clear) || (acc_q >= level && level != 32'h00000000);
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			acc_q <= 32'h00000000;
			trip_q <= 1'b0;
		end else if (ce) begin
			acc_q <= acc_d;
			trip_q <= trip_d;
		end
	end

	assign trip = trip_q;

	a_trip_at_level: assert property (@(posedge clock) disable iff (!rstn)
		(ce && acc_q >= level && level != 32'h00000000) |=> trip_q)
		else $error("trip not raised at level");
	a_trip_holds: assert property (@(posedge clock) disable iff (!rstn)
		(trip_q && !clear) |=> trip_q)
		else $error("trip dropped without clear");

endmodule : odp_acc

// file: src/odp_top.sv
// overload duty protection: duty selection, dependent settings and three overload trips
// Overview of operation
// - duty code 1 selects normal duty, code 2 heavy duty, for all overload logic.
// - factory defaults leave the duty selection at code 1, normal duty.
// - normal duty unit curve is 120 percent for 60 s, inverse time.
// - heavy duty unit curve is 150 percent for 60 s, inverse time.
// - normal duty above 122 percent uses a steep curve, 140 percent for 2.5 s.
// - normal duty at 1.0 Hz or less, trip point falls linearly to 60 percent.
// - heavy duty above 155 percent uses a steep curve, 175 percent for 2.5 s.
// - heavy duty at low frequency, trip point falls linearly to 75 percent.
// - heavy to normal duty change forces the drive current limit to 125.
// - motor trip fires after 60 s at breakdown reference, scaled by base reference.
// - motor rated current scales motor overload timing and the percent display.
// - unit curve percentages are taken against the selected duty rated current.
// - duty change reloads defaults of dependent current settings and the motor rated current range.
// assumes current, frequency and rated figures come from logic on the same clock
`timescale 1ns/1ps
module odp_top #(
	parameter int TICK_CYCLES = odp_pkg::ODP_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	input wire logic init_defaults,
	input wire logic fault_reset,
	input wire odp_pkg::odp_wr_type cfg_wr,
	input wire logic [15:0] output_current,
	input wire logic [15:0] output_freq,
	input wire logic [15:0] nd_rated_current,
	input wire logic [15:0] hd_rated_current,
	output logic [1:0] duty_rating_select,
	output logic [15:0] drive_current_limit_setting,
	output logic [15:0] motor_breakdown_ref,
	output logic [15:0] motor_overload_base_ref,
	output logic [15:0] motor_rated_current_setting,
	output logic [15:0] current_pct_display,
	output odp_pkg::odp_trip_type trips
);
	import odp_pkg::*;

	// ******************************
	// helpers
	// ******************************
	// percent of a reference, saturated; a zero reference reads as zero
	function automatic logic [15:0] pct_of(input logic [15:0] num, input logic [15:0] den);
		logic [31:0] q;
		q = 32'h00000000;
		if (den != 16'h0000)
			q = ({16'h0000, num} * {16'h0000, ODP_PCT_FULL}) / {16'h0000, den};
		pct_of = (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
	endfunction : pct_of

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	// accumulator level for a percent excess held for a number of ticks
	function automatic logic [31:0] level_of(input logic [15:0] excess, input int ticks);
		level_of = {16'h0000, excess} * ticks[31:0];
	endfunction : level_of

	// ******************************
	// settings
	// ******************************
	logic [1:0] duty_q, duty_d;
	logic [15:0] limit_q, limit_d, brk_q, brk_d, base_q, base_d, mrated_q, mrated_d;
	logic [15:0] duty_rated, mrated_min;
	logic hd_to_nd;

	always_comb begin
		duty_rated = (duty_q == ODP_DUTY_HD) ? hd_rated_current : nd_rated_current;
		mrated_min = 16'((32'(hd_rated_current) * 32'(ODP_MRATED_MIN_NUM)) / 32'(ODP_MRATED_MIN_DEN));
	end

	// motor rated writes are clamped to the duty now in force, limit and breakdown to fixed ranges
	always_comb begin
		duty_d = duty_q;
		limit_d = limit_q;
		brk_d = brk_q;
		base_d = base_q;
		mrated_d = clamp(mrated_q, mrated_min, duty_rated);
		hd_to_nd = 1'b0;
		if (init_defaults) begin
			duty_d = ODP_DUTY_ND;
			limit_d = ODP_LIM_DEF_ND;
			brk_d = ODP_BRK_DEF_ND;
			base_d = ODP_BASE_DEF;
			mrated_d = nd_rated_current;
		end else if (cfg_wr.wr) begin
			case (cfg_wr.sel)
				ODP_SEL_DUTY: begin
					// other codes are refused so the mode is never undefined
					if (cfg_wr.data[15:0] == {14'h0000, ODP_DUTY_ND} ||
						cfg_wr.data[15:0] == {14'h0000, ODP_DUTY_HD}) begin
						duty_d = cfg_wr.data[1:0];
					end
					if (duty_d != duty_q) begin
						hd_to_nd = (duty_d == ODP_DUTY_ND);
						limit_d = hd_to_nd ? ODP_LIM_DEF_ND : ODP_LIM_DEF_HD;
						brk_d = hd_to_nd ? ODP_BRK_DEF_ND : ODP_BRK_DEF_HD;
						mrated_d = hd_to_nd ? nd_rated_current : hd_rated_current;
					end
				end
				ODP_SEL_LIMIT: limit_d = clamp(cfg_wr.data, ODP_LIM_MIN, ODP_LIM_MAX);
				ODP_SEL_BRK: brk_d = clamp(cfg_wr.data, ODP_BRK_MIN, ODP_BRK_MAX);
				ODP_SEL_BASE: base_d = (cfg_wr.data < ODP_BASE_MIN) ? ODP_BASE_MIN : cfg_wr.data;
				ODP_SEL_MRATED: mrated_d = clamp(cfg_wr.data, mrated_min, duty_rated);
				default: duty_d = duty_q;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			duty_q <= ODP_DUTY_ND;
			limit_q <= ODP_LIM_DEF_ND;
			brk_q <= ODP_BRK_DEF_ND;
			base_q <= ODP_BASE_DEF;
			mrated_q <= 16'h0000;
		end else if (ce) begin
			duty_q <= duty_d;
			limit_q <= limit_d;
			brk_q <= brk_d;
			base_q <= base_d;
			mrated_q <= mrated_d;
		end
	end

	// ******************************
	// timebase
	// ******************************
	logic [31:0] tcnt_q, tcnt_d;
	logic tick;

	always_comb begin
		tick = (tcnt_q >= 32'(TICK_CYCLES - 1));
		tcnt_d = tick ? 32'h00000000 : tcnt_q + 32'h00000001;
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			tcnt_q <= 32'h00000000;
		else if (ce)
			tcnt_q <= tcnt_d;
	end

	// ******************************
	// curve selection
	// ******************************
	logic [15:0] unit_pct, motor_pct, motor_eff, trip_pt, main_pick, steep_on, steep_trip;
	logic [15:0] full_pt, low_pt, margin, lowf_span;
	logic [31:0] main_lvl, steep_lvl, motor_lvl;

	always_comb begin
		unit_pct = pct_of(output_current, duty_rated);
		motor_pct = pct_of(output_current, mrated_q);
		motor_eff = pct_of(motor_pct, base_q);
		if (duty_q == ODP_DUTY_HD) begin
			full_pt = ODP_HD_MAIN;
			low_pt = ODP_HD_LOWF;
			margin = ODP_HD_MARGIN;
			steep_on = ODP_HD_STEEP_ON;
			steep_trip = ODP_HD_STEEP_TRIP;
		end else begin
			full_pt = ODP_ND_MAIN;
			low_pt = ODP_ND_LOWF;
			margin = ODP_ND_MARGIN;
			steep_on = ODP_ND_STEEP_ON;
			steep_trip = ODP_ND_STEEP_TRIP;
		end
		// the trip point slides linearly toward its low value below 1.0 Hz
		lowf_span = 16'((32'(full_pt - low_pt) * 32'(output_freq)) / 32'(ODP_LOWF_HZ));
		trip_pt = (output_freq <= ODP_LOWF_HZ) ? low_pt + lowf_span : full_pt;
		main_pick = trip_pt - margin;
		main_lvl = level_of(margin, ODP_LONG_TICKS);
		steep_lvl = level_of(steep_trip - steep_on, ODP_SHORT_TICKS);
		motor_lvl = level_of(brk_q - ODP_PCT_FULL, ODP_LONG_TICKS);
	end

	// ******************************
	// trip accumulators
	// ******************************
	logic unit_main_trip, unit_steep_trip, motor_trip;

	odp_acc u_main (.clock(clock), .rstn(rstn), .ce(ce), .tick(tick), .clear(fault_reset),
		.pct(unit_pct), .pickup(main_pick), .level(main_lvl), .trip(unit_main_trip));
	odp_acc u_steep (.clock(clock), .rstn(rstn), .ce(ce), .tick(tick), .clear(fault_reset),
		.pct(unit_pct), .pickup(steep_on), .level(steep_lvl), .trip(unit_steep_trip));
	odp_acc u_motor (.clock(clock), .rstn(rstn), .ce(ce), .tick(tick), .clear(fault_reset),
		.pct(motor_eff), .pickup(ODP_PCT_FULL), .level(motor_lvl), .trip(motor_trip));

	// display percent is registered so it cannot glitch through the divider
	logic [15:0] disp_q;

	always_ff @(posedge clock) begin
		if (!rstn)
			disp_q <= 16'h0000;
		else if (ce)
			disp_q <= motor_pct;
	end

	assign duty_rating_select = duty_q;
	assign drive_current_limit_setting = limit_q;
	assign motor_breakdown_ref = brk_q;
	assign motor_overload_base_ref = base_q;
	assign motor_rated_current_setting = mrated_q;
	assign current_pct_display = disp_q;
	assign trips = '{unit_main: unit_main_trip, unit_steep: unit_steep_trip, motor: motor_trip};

	// ******************************
	// checks
	// ******************************
	a_duty_reset_nd: assert property (@(posedge clock) !rstn |=> duty_q == ODP_DUTY_ND)
		else $error("duty not normal after reset");
	a_duty_code_legal: assert property (@(posedge clock) disable iff (!rstn)
		duty_q == ODP_DUTY_ND || duty_q == ODP_DUTY_HD)
		else $error("illegal duty code");
	a_limit_forced: assert property (@(posedge clock) disable iff (!rstn)
		(ce && !init_defaults && duty_q == ODP_DUTY_HD && duty_d == ODP_DUTY_ND)
		|=> limit_q == ODP_LIM_DEF_ND && duty_q == ODP_DUTY_ND)
		else $error("limit not forced to 125");
	a_brk_default: assert property (@(posedge clock) disable iff (!rstn)
		(ce && !init_defaults && duty_q == ODP_DUTY_ND && duty_d == ODP_DUTY_HD)
		|=> brk_q == ODP_BRK_DEF_HD && limit_q == ODP_LIM_DEF_HD)
		else $error("heavy duty defaults not loaded");
	a_limit_range: assert property (@(posedge clock) disable iff (!rstn)
		limit_q >= ODP_LIM_MIN && limit_q <= ODP_LIM_MAX)
		else $error("current limit out of range");
	a_curve_full_speed: assert property (@(posedge clock) disable iff (!rstn)
		(output_freq > ODP_LOWF_HZ && duty_q == ODP_DUTY_ND) |-> main_pick == ODP_ND_MAIN - ODP_ND_MARGIN)
		else $error("normal duty pickup wrong");
	a_curve_zero_hz: assert property (@(posedge clock) disable iff (!rstn)
		(output_freq == 16'h0000 && duty_q == ODP_DUTY_HD) |-> trip_pt == ODP_HD_LOWF)
		else $error("heavy duty low speed point wrong");
	a_rated_by_duty: assert property (@(posedge clock) disable iff (!rstn)
		duty_q == ODP_DUTY_HD |-> duty_rated == hd_rated_current)
		else $error("wrong rated current reference");
	a_tick_single: assert property (@(posedge clock) disable iff (!rstn)
		(ce && tick && TICK_CYCLES > 1) |=> !tick)
		else $error("tick longer than one cycle");

endmodule : odp_top

// file: verification/tb.sv
// bench for the overload duty protection block: settings, duty changes and trip timing
// assumes odp_pkg is compiled first and odp_top runs with a short tick of two cycles
`timescale 1ns/1ps
module tb;
	import odp_pkg::*;
	localparam int TK = 2;
	logic clock;
	logic rstn;
	logic ce;
	logic init_defaults;
	logic fault_reset;
	odp_wr_type cfg_wr;
	logic [15:0] output_current;
	logic [15:0] output_freq;
	logic [15:0] nd_rated_current;
	logic [15:0] hd_rated_current;
	logic [1:0] duty_rating_select;
	logic [15:0] drive_current_limit_setting;
	logic [15:0] motor_breakdown_ref;
	logic [15:0] motor_overload_base_ref;
	logic [15:0] motor_rated_current_setting;
	logic [15:0] current_pct_display;
	odp_trip_type trips;
	int n_errors = 0;
	int compares = 0;

	// ******************************
	// device and clock
	// ******************************
	// short tick keeps the 2.5 s curves within 5000 cycles and the 60 s curves within 120000
	odp_top #(.TICK_CYCLES(TK)) DUT (.clock(clock), .rstn(rstn), .ce(ce), .init_defaults(init_defaults),
		.fault_reset(fault_reset), .cfg_wr(cfg_wr), .output_current(output_current), .output_freq(output_freq),
		.nd_rated_current(nd_rated_current), .hd_rated_current(hd_rated_current),
		.duty_rating_select(duty_rating_select), .drive_current_limit_setting(drive_current_limit_setting),
		.motor_breakdown_ref(motor_breakdown_ref), .motor_overload_base_ref(motor_overload_base_ref),
		.motor_rated_current_setting(motor_rated_current_setting), .current_pct_display(current_pct_display),
		.trips(trips));

	// free-running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ******************************
	// shared tasks
	// ******************************
	task automatic results();
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	// reset also clears every accumulator, so each trip run starts from zero
	task automatic do_reset();
		@(posedge clock);
		rstn <= 1'b0;
		output_current <= 16'h0000;
		output_freq <= 16'h1388;
		nd_rated_current <= 16'h03E8;
		cyc(16);
		@(posedge clock);
		rstn <= 1'b1;
		#1;
	endtask : do_reset

	task automatic wr(input odp_sel_type s, input logic [15:0] d);
		@(posedge clock);
		cfg_wr <= '{wr: 1'b1, sel: s, data: d};
		@(posedge clock);
		cfg_wr.wr <= 1'b0;
		#1;
	endtask : wr

	// bounded wait for one trip bit, then judge the elapsed cycles against a window
	task automatic wait_trip(input int b, input int lo, input int hi);
		int n;
		n = 0;
		while (trips[b] !== 1'b1) begin
			cyc(1);
			n++;
			if (n > hi) begin
				chk(n, hi);
				results();
			end
		end
		chk(n >= lo, 1);
	endtask : wait_trip

	// ******************************
	// scenarios
	// ******************************
	task automatic t_settings();
		do_reset();
		chk(duty_rating_select, ODP_DUTY_ND);
		chk(drive_current_limit_setting, 16'h007D);
		chk({motor_breakdown_ref, motor_overload_base_ref}, {16'h0078, 16'h0064});
		chk(trips, 3'h0);
		// duty goes first, since it reloads the dependent settings
		wr(ODP_SEL_DUTY, 16'h0002);
		chk(duty_rating_select, ODP_DUTY_HD);
		chk({drive_current_limit_setting, motor_breakdown_ref}, {16'h009B, 16'h0096});
		wr(ODP_SEL_LIMIT, 16'h0190);
		chk(drive_current_limit_setting, 16'h012C);
		wr(ODP_SEL_LIMIT, 16'h000A);
		chk(drive_current_limit_setting, 16'h0032);
		wr(ODP_SEL_DUTY, 16'h0001);
		chk(drive_current_limit_setting, 16'h007D);
		chk(motor_breakdown_ref, 16'h0078);
		wr(ODP_SEL_DUTY, 16'h0003);
		chk(duty_rating_select, ODP_DUTY_ND);
		// a frozen block must ignore panel writes
		@(posedge clock);
		ce <= 1'b0;
		wr(ODP_SEL_DUTY, 16'h0002);
		@(posedge clock);
		ce <= 1'b1;
		#1;
		chk(duty_rating_select, ODP_DUTY_ND);
		wr(ODP_SEL_MRATED, 16'h1388);
		chk(motor_rated_current_setting, 16'h03E8);
		wr(ODP_SEL_MRATED, 16'h0064);
		chk(motor_rated_current_setting, 16'h00F0);
		wr(ODP_SEL_MRATED, 16'h03E8);
		@(posedge clock);
		output_current <= 16'h0578;
		cyc(4);
		chk(current_pct_display, 16'h008C);
		wr(ODP_SEL_BRK, 16'h00C8);
		wr(ODP_SEL_BASE, 16'h0014);
		chk(motor_overload_base_ref, 16'h0032);
		@(posedge clock);
		init_defaults <= 1'b1;
		@(posedge clock);
		init_defaults <= 1'b0;
		#1;
		chk({motor_breakdown_ref, motor_rated_current_setting}, {16'h0078, 16'h03E8});
		chk(motor_overload_base_ref, 16'h0064);
	endtask : t_settings

	// normal duty at 140 percent of its own rating: steep curve, 2500 ticks
	task automatic t_nd_steep();
		do_reset();
		@(posedge clock);
		output_current <= 16'h0578;
		wait_trip(1, 2450 * TK, 2550 * TK);
	endtask : t_nd_steep

	// heavy duty at 175 percent of the heavy rating: steep curve, 2500 ticks
	task automatic t_hd_steep();
		do_reset();
		wr(ODP_SEL_DUTY, 16'h0002);
		@(posedge clock);
		output_current <= 16'h0578;
		wait_trip(1, 2450 * TK, 2550 * TK);
		chk(trips.unit_main, 1'b0);
	endtask : t_hd_steep

	// motor at 300 percent with breakdown 110: 3000 ticks, then sticky until cleared
	// a large unit rating keeps the unit curves quiet, so the final clear really empties trips
	task automatic t_motor();
		do_reset();
		wr(ODP_SEL_MRATED, 16'h03E8);
		wr(ODP_SEL_BRK, 16'h006E);
		@(posedge clock);
		output_current <= 16'h0BB8;
		nd_rated_current <= 16'h1388;
		wait_trip(0, 2950 * TK, 3050 * TK);
		@(posedge clock);
		output_current <= 16'h0000;
		cyc(20);
		chk(trips.motor, 1'b1);
		@(posedge clock);
		fault_reset <= 1'b1;
		cyc(4);
		@(posedge clock);
		fault_reset <= 1'b0;
		#1;
		chk(trips, 3'h0);
	endtask : t_motor

	// standstill normal duty: trip point 60, so 100 percent trips after 20000 ticks
	task automatic t_low_freq();
		do_reset();
		@(posedge clock);
		output_freq <= 16'h0000;
		output_current <= 16'h03E8;
		wait_trip(2, 19800 * TK, 20200 * TK);
	endtask : t_low_freq

	// ******************************
	// main sequence
	// ******************************
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		init_defaults = 1'b0;
		fault_reset = 1'b0;
		cfg_wr = '0;
		output_current = 16'h0000;
		output_freq = 16'h1388;
		nd_rated_current = 16'h03E8;
		hd_rated_current = 16'h0320;
		t_settings();
		t_nd_steep();
		t_hd_steep();
		t_motor();
		t_low_freq();
		results();
	end
endmodule : tb
